// ==== scp_consts.vh ====
// constants for the text command parser of the dc source
`ifndef SCP_CONSTS_VH
`define SCP_CONSTS_VH
// list store shape
`define SCP_LIST_DEPTH 250
`define SCP_LIST_AW 8
// dwell limits in seconds and in 10 ms steps
`define SCP_DWELL_MIN_S 0.01
`define SCP_DWELL_MAX_S 655.35
`define SCP_DWELL_MIN 32'h0000_0001
`define SCP_DWELL_MAX 32'h0000_ffff
// token and tree limits
`define SCP_TOK_BYTES 12
`define SCP_MAX_DEPTH 2'd3
// character codes
`define SCP_CH_NL 8'h0a
`define SCP_CH_CR 8'h0d
`define SCP_CH_SPACE 8'h20
`define SCP_CH_STAR 8'h2a
`define SCP_CH_DOT 8'h2e
`define SCP_CH_COLON 8'h3a
`define SCP_CH_SEMI 8'h3b
`define SCP_CH_QUERY 8'h3f
`define SCP_CH_ZERO 8'h30
`define SCP_CH_NINE 8'h39
`define SCP_CH_UA 8'h41
`define SCP_CH_UZ 8'h5a
`define SCP_CH_LA 8'h61
`define SCP_CH_LZ 8'h7a
`define SCP_CH_UN 8'h4e
`define SCP_CASE_GAP 8'h20
// default calibration access code and reset values
`define SCP_CAL_CODE_DEF 24'h000000
`define SCP_WORD_RST 16'h0000
`endif

// ==== scp_parser.v ====
// text command parser with trigger, list, status and calibration gating
`timescale 1ns/100ps
`default_nettype none
`include "scp_consts.vh"
// Summary of operation
// - armed trigger fires on get, star trg, trig
// - unarmed trigger commands are silently dropped
// - volatile list of 250 current/voltage/dwell entries
// - dwell accepted only from 0.01 to 655.35 s
// - operation and questionable condition/enable/event groups
// - calibration entry needs correct access code first
// - no mixing panel and remote calibration steps
// - voltage and current parts, zero and full, separately savable
// - save writes new calibration data to nonvolatile store
// - short form: whole, first four, or three
// - any other truncation is an error
// - keyword letters match case-insensitively
// - colon joins keywords, steps one tree level
// - trailing question mark makes the command a query
// - parameter follows last keyword after a space
// - measurement queries return sensed voltage and current
// - message units separated by semicolons
// - only new line terminates a message
// - terminator or leading colon returns to root
module scp_parser #(
  parameter LIST_DEPTH = `SCP_LIST_DEPTH,
  parameter [23:0] CAL_CODE = `SCP_CAL_CODE_DEF
) (
  input wire core_clk,
  input wire rst,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire get_trig,
  input wire fp_cal_active,
  input wire [15:0] meas_volt,
  input wire [15:0] meas_curr,
  input wire [15:0] oper_cond,
  input wire [15:0] ques_cond,
  input wire [7:0] list_rd_idx,
  output reg trig_pulse,
  output reg trig_armed,
  output reg [15:0] set_volt,
  output reg [15:0] set_curr,
  output reg output_on,
  output reg resp_valid,
  output reg [15:0] resp_data,
  output reg err_pulse,
  output reg [15:0] oper_event,
  output reg [15:0] oper_enable,
  output reg [15:0] ques_event,
  output reg [15:0] ques_enable,
  output reg oper_summary,
  output reg ques_summary,
  output reg cal_mode,
  output reg cal_step_pulse,
  output reg [1:0] cal_step_sel,
  output reg nvm_write,
  output reg [1:0] nvm_parts,
  output reg [7:0] list_count,
  output reg [15:0] list_rd_volt,
  output reg [15:0] list_rd_curr,
  output reg [15:0] list_rd_dwell
);
  localparam [3:0] S_KEY = 4'b0001, S_QEND = 4'b0010;
  localparam [3:0] S_PARM = 4'b0100, S_SKIP = 4'b1000;
  localparam NKW = 22;
  localparam [4:0] K_ABOR = 5'd0, K_CAL = 5'd1, K_INIT = 5'd2;
  localparam [4:0] K_LIST = 5'd3, K_MEAS = 5'd4, K_OUTP = 5'd5;
  localparam [4:0] K_STAT = 5'd6, K_TRIG = 5'd7, K_VOLT = 5'd8;
  localparam [4:0] K_CURR = 5'd9, K_OPER = 5'd10, K_QUES = 5'd11;
  localparam [4:0] K_COND = 5'd12, K_ENAB = 5'd13, K_EVEN = 5'd14;
  localparam [4:0] K_DWEL = 5'd15, K_CODE = 5'd16, K_ZERO = 5'd17;
  localparam [4:0] K_FULL = 5'd18, K_SAVE = 5'd19, K_CLE = 5'd20;
  localparam [4:0] K_STRG = 5'd21;

  function [95:0] kw_text;
    input integer i;
    case (i)
      0: kw_text = "ABORT";
      1: kw_text = "CALIBRATE";
      2: kw_text = "INITIATE";
      3: kw_text = "LIST";
      4: kw_text = "MEASURE";
      5: kw_text = "OUTPUT";
      6: kw_text = "STATUS";
      7: kw_text = "TRIGGER";
      8: kw_text = "VOLTAGE";
      9: kw_text = "CURRENT";
      10: kw_text = "OPERATION";
      11: kw_text = "QUESTIONABLE";
      12: kw_text = "CONDITION";
      13: kw_text = "ENABLE";
      14: kw_text = "EVENT";
      15: kw_text = "DWELL";
      16: kw_text = "CODE";
      17: kw_text = "ZERO";
      18: kw_text = "FULL";
      19: kw_text = "SAVE";
      20: kw_text = "CLEAR";
      21: kw_text = "*TRG";
      default: kw_text = 96'h0;
    endcase
  endfunction

  // short form: whole up to four, else four unless fourth is a vowel
  function [95:0] kw_short;
    input [95:0] t;
    integer n, s, k;
    reg [7:0] c4;
    begin
      n = 0;
      for (k = 0; k < `SCP_TOK_BYTES; k = k + 1) begin
        if (t[8*k +: 8] != 8'h00) n = k + 1;
      end
      c4 = (n > 4) ? t[8*(n-4) +: 8] : 8'h00;
      if (n <= 4) s = n;
      else if (c4 == "A" || c4 == "E" || c4 == "I" || c4 == "O" ||
               c4 == "U") s = 3;
      else s = 4;
      kw_short = t >> (8 * (n - s));
    end
  endfunction

  reg [3:0] state_reg;
  reg [95:0] tok_reg;
  reg [3:0] tok_len_reg;
  reg [14:0] path_reg;
  reg [1:0] depth_reg;
  reg ustart_reg, query_reg, has_param_reg, dot_reg;
  reg [1:0] frac_reg;
  reg [23:0] pacc_reg;
  reg code_ok_reg;
  reg [3:0] steps_reg;
  reg [7:0] ptr_reg;
  reg [15:0] oper_cond_d_reg, ques_cond_d_reg;
  reg lw_en_reg;
  reg [1:0] lw_sel_reg;
  reg [7:0] lw_idx_reg;
  reg [15:0] lw_val_reg;
  reg [15:0] list_volt [0:LIST_DEPTH-1];
  reg [15:0] list_curr [0:LIST_DEPTH-1];
  reg [15:0] list_dwel [0:LIST_DEPTH-1];

  // case folding before any compare
  wire is_low = rx_data >= `SCP_CH_LA && rx_data <= `SCP_CH_LZ;
  wire [7:0] ch = is_low ? rx_data - `SCP_CASE_GAP : rx_data;
  wire is_alpha = ch >= `SCP_CH_UA && ch <= `SCP_CH_UZ;
  wire is_digit = ch >= `SCP_CH_ZERO && ch <= `SCP_CH_NINE;
  wire is_end = ch == `SCP_CH_NL || ch == `SCP_CH_SEMI;
  wire [NKW-1:0] kw_hit;
  reg [4:0] kw_id;
  reg kw_found;
  reg [14:0] path_ins;

  genvar g;
  generate
    for (g = 0; g < NKW; g = g + 1) begin : g_kw
      // only full long or exact short form hits
      assign kw_hit[g] = tok_len_reg != 4'h0 && (tok_reg == kw_text(g) ||
        tok_reg == kw_short(kw_text(g)));
    end
  endgenerate

  integer i;
  always @* begin
    kw_id = 5'd0;
    kw_found = 1'b0;
    for (i = 0; i < NKW; i = i + 1) begin
      if (kw_hit[i] && !kw_found) begin
        kw_id = i[4:0];
        kw_found = 1'b1;
      end
    end
    path_ins = path_reg;
    if (depth_reg != `SCP_MAX_DEPTH) path_ins[5*depth_reg +: 5] = kw_id;
  end

  wire kw_ok = kw_found && depth_reg != `SCP_MAX_DEPTH;
  wire in_key = state_reg == S_KEY;
  wire do_exec = rx_valid && is_end && ((in_key && kw_ok) ||
    state_reg == S_QEND || state_reg == S_PARM);
  wire [1:0] ex_n = in_key ? depth_reg + 2'd1 : depth_reg;
  wire [14:0] ex_path = in_key ? path_ins : path_reg;
  wire [4:0] e0 = ex_path[4:0];
  wire [4:0] e1 = ex_path[9:5];
  wire [4:0] e2 = ex_path[14:10];
  wire [31:0] pacc_ext = {8'h00, pacc_reg};
  wire [31:0] pv = (frac_reg == 2'd0) ? pacc_ext * 32'd100 :
    (frac_reg == 2'd1) ? pacc_ext * 32'd10 : pacc_ext;
  wire pv_fits = pv[31:16] == 16'h0000;
  wire [27:0] pacc_x10 = {4'h0, pacc_reg} * 28'd10;
  wire [15:0] oper_rise = oper_cond & ~oper_cond_d_reg;
  wire [15:0] ques_rise = ques_cond & ~ques_cond_d_reg;

  task unit_clear;
    begin
      tok_reg <= 96'h0;
      tok_len_reg <= 4'h0;
      query_reg <= 1'b0;
      has_param_reg <= 1'b0;
      dot_reg <= 1'b0;
      frac_reg <= 2'd0;
      pacc_reg <= 24'h0;
    end
  endtask

  // terminator always lands at root, semicolon keeps the stem
  task unit_end;
    begin
      unit_clear;
      ustart_reg <= 1'b1;
      state_reg <= S_KEY;
      depth_reg <= (ch == `SCP_CH_NL) ? 2'd0 : ex_n - 2'd1;
    end
  endtask

  // rest of message is dropped so a broken unit cannot half-execute
  task syntax_error;
    begin
      err_pulse <= 1'b1;
      unit_clear;
      if (ch == `SCP_CH_NL) begin
        state_reg <= S_KEY;
        depth_reg <= 2'd0;
        ustart_reg <= 1'b1;
      end else begin
        state_reg <= S_SKIP;
      end
    end
  endtask

  task answer;
    input [15:0] v;
    begin
      resp_valid <= 1'b1;
      resp_data <= v;
    end
  endtask

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_KEY;
      tok_reg <= 96'h0;
      tok_len_reg <= 4'h0;
      path_reg <= 15'h0;
      depth_reg <= 2'd0;
      ustart_reg <= 1'b1;
      query_reg <= 1'b0;
      has_param_reg <= 1'b0;
      dot_reg <= 1'b0;
      frac_reg <= 2'd0;
      pacc_reg <= 24'h0;
      code_ok_reg <= 1'b0;
      steps_reg <= 4'h0;
      ptr_reg <= 8'h00;
      oper_cond_d_reg <= `SCP_WORD_RST;
      ques_cond_d_reg <= `SCP_WORD_RST;
      lw_en_reg <= 1'b0;
      lw_sel_reg <= 2'd0;
      lw_idx_reg <= 8'h00;
      lw_val_reg <= `SCP_WORD_RST;
      trig_pulse <= 1'b0;
      trig_armed <= 1'b0;
      set_volt <= `SCP_WORD_RST;
      set_curr <= `SCP_WORD_RST;
      output_on <= 1'b0;
      resp_valid <= 1'b0;
      resp_data <= `SCP_WORD_RST;
      err_pulse <= 1'b0;
      oper_event <= `SCP_WORD_RST;
      oper_enable <= `SCP_WORD_RST;
      ques_event <= `SCP_WORD_RST;
      ques_enable <= `SCP_WORD_RST;
      oper_summary <= 1'b0;
      ques_summary <= 1'b0;
      cal_mode <= 1'b0;
      cal_step_pulse <= 1'b0;
      cal_step_sel <= 2'd0;
      nvm_write <= 1'b0;
      nvm_parts <= 2'd0;
      list_count <= 8'h00;
    end else begin
      trig_pulse <= get_trig && trig_armed;
      resp_valid <= 1'b0;
      err_pulse <= 1'b0;
      cal_step_pulse <= 1'b0;
      nvm_write <= 1'b0;
      lw_en_reg <= 1'b0;
      list_count <= ptr_reg;
      oper_cond_d_reg <= oper_cond;
      ques_cond_d_reg <= ques_cond;
      oper_event <= oper_event | oper_rise;
      ques_event <= ques_event | ques_rise;
      oper_summary <= |(oper_event & oper_enable);
      ques_summary <= |(ques_event & ques_enable);
      if (rx_valid) begin
        case (state_reg)
          S_KEY: begin
            if (is_alpha || ch == `SCP_CH_STAR) begin
              if (tok_len_reg == `SCP_TOK_BYTES) begin
                syntax_error;
              end else begin
                tok_reg <= {tok_reg[87:0], ch};
                tok_len_reg <= tok_len_reg + 4'h1;
                ustart_reg <= 1'b0;
              end
            end else if (ch == `SCP_CH_CR) begin
              // carriage return is tolerated, never a terminator
            end else if (ch == `SCP_CH_SPACE && tok_len_reg == 4'h0 &&
                         ustart_reg) begin
              // blank after a semicolon
            end else if (ch == `SCP_CH_COLON && tok_len_reg == 4'h0 &&
                         ustart_reg) begin
              depth_reg <= 2'd0;
            end else if (!kw_ok) begin
              syntax_error;
            end else begin
              path_reg <= path_ins;
              depth_reg <= depth_reg + 2'd1;
              tok_reg <= 96'h0;
              tok_len_reg <= 4'h0;
              case (ch)
                `SCP_CH_COLON: ;
                `SCP_CH_QUERY: begin
                  query_reg <= 1'b1;
                  state_reg <= S_QEND;
                end
                `SCP_CH_SPACE: state_reg <= S_PARM;
                `SCP_CH_NL, `SCP_CH_SEMI: unit_end;
                default: syntax_error;
              endcase
            end
          end
          S_QEND: begin
            if (ch == `SCP_CH_SPACE) state_reg <= S_PARM;
            else if (is_end) unit_end;
            else if (ch != `SCP_CH_CR) syntax_error;
          end
          S_PARM: begin
            if (is_digit) begin
              has_param_reg <= 1'b1;
              // digits past hundredths carry no weight
              if (!(dot_reg && frac_reg == 2'd2)) begin
                pacc_reg <= pacc_x10[23:0] + {16'h0, ch - `SCP_CH_ZERO};
                frac_reg <= frac_reg + {1'b0, dot_reg};
              end
            end else if (ch == `SCP_CH_DOT && !dot_reg) begin
              dot_reg <= 1'b1;
            end else if (is_alpha) begin
              has_param_reg <= 1'b1;
              if (ch == `SCP_CH_UN) pacc_reg <= 24'h1;
            end else if (is_end) begin
              unit_end;
            end else if (ch != `SCP_CH_SPACE && ch != `SCP_CH_CR) begin
              syntax_error;
            end
          end
          S_SKIP: begin
            if (ch == `SCP_CH_NL) begin
              state_reg <= S_KEY;
              depth_reg <= 2'd0;
              ustart_reg <= 1'b1;
            end
          end
          default: state_reg <= S_KEY;
        endcase
      end
      if (do_exec) begin
        case (ex_n)
          2'd1: begin
            case (e0)
              K_INIT: trig_armed <= 1'b1;
              K_ABOR: trig_armed <= 1'b0;
              // unarmed trigger is dropped without error
              K_TRIG, K_STRG: trig_pulse <= trig_armed;
              K_VOLT: begin
                if (query_reg) answer(set_volt);
                else if (has_param_reg && pv_fits) set_volt <= pv[15:0];
                else err_pulse <= 1'b1;
              end
              K_CURR: begin
                if (query_reg) answer(set_curr);
                else if (has_param_reg && pv_fits) set_curr <= pv[15:0];
                else err_pulse <= 1'b1;
              end
              K_OUTP: begin
                if (query_reg) answer({15'h0, output_on});
                else output_on <= pv != 32'h0;
              end
              default: err_pulse <= 1'b1;
            endcase
          end
          2'd2: begin
            if (e0 == K_MEAS && query_reg && e1 == K_VOLT) begin
              answer(meas_volt);
            end else if (e0 == K_MEAS && query_reg && e1 == K_CURR) begin
              answer(meas_curr);
            end else if (e0 == K_LIST && e1 == K_CLE) begin
              ptr_reg <= 8'h00;
            end else if (e0 == K_LIST && query_reg) begin
              answer({8'h00, ptr_reg});
            end else if (e0 == K_LIST && (e1 == K_VOLT || e1 == K_CURR ||
                         e1 == K_DWEL) && ptr_reg < LIST_DEPTH &&
                         pv_fits && (e1 != K_DWEL ||
                         (pv >= `SCP_DWELL_MIN && pv <= `SCP_DWELL_MAX))) begin
              lw_en_reg <= 1'b1;
              lw_sel_reg <= e1 == K_VOLT ? 2'd0 : e1 == K_CURR ? 2'd1 : 2'd2;
              lw_idx_reg <= ptr_reg;
              lw_val_reg <= pv[15:0];
              if (e1 == K_DWEL) ptr_reg <= ptr_reg + 8'h01;
            end else if (e0 == K_CAL && e1 == K_CODE && !query_reg) begin
              code_ok_reg <= pv[23:0] == CAL_CODE;
            end else if (e0 == K_CAL && e1 == K_STAT && query_reg) begin
              answer({15'h0, cal_mode});
            end else if (e0 == K_CAL && e1 == K_STAT && pv != 32'h0) begin
              // panel session owns the calibration until it ends
              if (code_ok_reg && !fp_cal_active && !cal_mode) begin
                cal_mode <= 1'b1;
                steps_reg <= 4'h0;
              end else begin
                err_pulse <= 1'b1;
              end
            end else if (e0 == K_CAL && e1 == K_STAT) begin
              cal_mode <= 1'b0;
              code_ok_reg <= 1'b0;
            end else if (e0 == K_CAL && e1 == K_SAVE && cal_mode &&
                         (&steps_reg[1:0] || &steps_reg[3:2])) begin
              nvm_write <= 1'b1;
              nvm_parts <= {&steps_reg[3:2], &steps_reg[1:0]};
            end else begin
              err_pulse <= 1'b1;
            end
          end
          2'd3: begin
            if (e0 == K_STAT && (e1 == K_OPER || e1 == K_QUES)) begin
              case (e2)
                K_ENAB: begin
                  if (query_reg) begin
                    answer(e1 == K_OPER ? oper_enable : ques_enable);
                  end else if (e1 == K_OPER) begin
                    oper_enable <= pv[15:0];
                  end else begin
                    ques_enable <= pv[15:0];
                  end
                end
                // read clears, but a rise in the same cycle stays set
                K_EVEN: begin
                  answer(e1 == K_OPER ? oper_event : ques_event);
                  if (e1 == K_OPER) oper_event <= oper_rise;
                  else ques_event <= ques_rise;
                end
                K_COND: answer(e1 == K_OPER ? oper_cond : ques_cond);
                default: err_pulse <= 1'b1;
              endcase
            end else if (e0 == K_CAL && cal_mode && !fp_cal_active &&
                         (e1 == K_VOLT || e1 == K_CURR) &&
                         (e2 == K_ZERO || e2 == K_FULL)) begin
              cal_step_pulse <= 1'b1;
              cal_step_sel <= {e1 == K_CURR, e2 == K_FULL};
              steps_reg[{e1 == K_CURR, e2 == K_FULL}] <= 1'b1;
            end else begin
              err_pulse <= 1'b1;
            end
          end
          default: err_pulse <= 1'b1;
        endcase
      end
    end
  end

  // list contents are volatile data, so no reset on the storage
  always @(posedge core_clk) begin
    if (lw_en_reg) begin
      case (lw_sel_reg)
        2'd0: list_volt[lw_idx_reg] <= lw_val_reg;
        2'd1: list_curr[lw_idx_reg] <= lw_val_reg;
        default: list_dwel[lw_idx_reg] <= lw_val_reg;
      endcase
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      list_rd_volt <= `SCP_WORD_RST;
      list_rd_curr <= `SCP_WORD_RST;
      list_rd_dwell <= `SCP_WORD_RST;
    end else if (list_rd_idx < ptr_reg) begin
      list_rd_volt <= list_volt[list_rd_idx];
      list_rd_curr <= list_curr[list_rd_idx];
      list_rd_dwell <= list_dwel[list_rd_idx];
    end else begin
      list_rd_volt <= `SCP_WORD_RST;
      list_rd_curr <= `SCP_WORD_RST;
      list_rd_dwell <= `SCP_WORD_RST;
    end
  end
endmodule // scp_parser
`default_nettype wire

// ==== scp_parser_props.sv ====
// port checks for the text command parser
`timescale 1ns/100ps
`default_nettype none
module scp_parser_props #(
  parameter LIST_DEPTH = 250
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic get_trig,
  input wire logic fp_cal_active,
  input wire logic [15:0] oper_cond,
  input wire logic [15:0] ques_cond,
  input wire logic trig_pulse,
  input wire logic trig_armed,
  input wire logic resp_valid,
  input wire logic [15:0] oper_event,
  input wire logic [15:0] oper_enable,
  input wire logic [15:0] ques_event,
  input wire logic [15:0] ques_enable,
  input wire logic oper_summary,
  input wire logic ques_summary,
  input wire logic cal_mode,
  input wire logic cal_step_pulse,
  input wire logic nvm_write,
  input wire logic [1:0] nvm_parts,
  input wire logic [7:0] list_count
);
  // unit ends on ';' or new line only
  wire term_seen = rx_valid && (rx_data == 8'h0a || rx_data == 8'h3b);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  armed_trig_a: assert property (
    get_trig && trig_armed |-> ##[1:2] trig_pulse)
    else $error("armed trigger gave no pulse");
  unarmed_trig_a: assert property (trig_pulse |-> $past(trig_armed))
    else $error("trigger pulse while unarmed");
  list_cap_a: assert property (list_count <= LIST_DEPTH)
    else $error("list count above depth");
  cal_entry_a: assert property (
    $rose(cal_mode) |-> !$past(fp_cal_active))
    else $error("remote cal opened during panel session");
  cal_step_a: assert property (
    cal_step_pulse |-> cal_mode && !$past(fp_cal_active))
    else $error("cal step outside remote session");
  nvm_save_a: assert property (
    nvm_write |-> cal_mode && nvm_parts != 2'b00)
    else $error("save without a finished part");
  oper_sum_a: assert property (
    oper_summary == |($past(oper_event) & $past(oper_enable)))
    else $error("operation summary wrong");
  ques_sum_a: assert property (
    ques_summary == |($past(ques_event) & $past(ques_enable)))
    else $error("questionable summary wrong");
  oper_event_a: assert property (
    $rose(oper_cond[0]) |-> ##[1:2] oper_event[0])
    else $error("operation event not latched");
  ques_event_a: assert property (
    $rose(ques_cond[15]) |-> ##[1:2] ques_event[15])
    else $error("questionable event not latched");
  resp_term_a: assert property (
    resp_valid |-> $past(term_seen) || $past(term_seen, 2))
    else $error("answer without unit end");
  cover property (resp_valid);
  cover property (trig_pulse);
  cover property (cal_step_pulse);
  cover property (nvm_write);
endmodule // scp_parser_props
bind scp_parser scp_parser_props #(.LIST_DEPTH(LIST_DEPTH)) u_props (.core_clk,
  .rst, .rx_data, .rx_valid, .get_trig, .fp_cal_active, .oper_cond, .ques_cond,
  .trig_pulse, .trig_armed, .resp_valid, .oper_event, .oper_enable, .ques_event,
  .ques_enable, .oper_summary, .ques_summary, .cal_mode, .cal_step_pulse,
  .nvm_write, .nvm_parts, .list_count);
`default_nettype wire

// ==== scp_host_model.sv ====
// host controller sending text program messages
`timescale 1ns/100ps
`default_nettype none
module scp_host_model (
  input wire logic core_clk,
  input wire logic rst,
  output var logic [7:0] rx_data,
  output var logic rx_valid
);
  int gap = 0;
  initial begin
    rx_data = 8'hff;
    rx_valid = 1'b0;
  end
  // call just after a rising edge; returns just after one
  task automatic send_msg(input string s);
    string m;
    int k;
    m = {s, "\n"};
    while (rst) begin
      @(posedge core_clk);
      #1;
    end
    for (k = 0; k < m.len(); k++) begin
      rx_data = m[k];
      rx_valid = 1'b1;
      @(posedge core_clk);
      #1;
      // valid held between chars when prompt, so no double drive
      if (gap > 0 || k == m.len() - 1) begin
        rx_valid = 1'b0;
        rx_data = ~m[k];
        // at least one idle edge, so a following message never
        // lowers and raises valid in the same step
        repeat ((gap > 0) ? gap : 1) begin
          @(posedge core_clk);
          #1;
        end
      end
    end
  endtask
endmodule // scp_host_model
`default_nettype wire

// ==== scp_parser_tb_top.sv ====
// self-checking bench for the text command parser
`timescale 1ns/100ps
`default_nettype none
module scp_parser_tb_top;
  logic core_clk = 0, rst = 1, get_trig = 0, fp_cal_active = 0;
  logic [15:0] meas_volt = 16'h1234, meas_curr = 16'h0abc;
  logic [15:0] oper_cond = 16'h0000, ques_cond = 16'h0000;
  logic [7:0] list_rd_idx = 8'h00;
  wire [7:0] rx_data, list_count;
  wire rx_valid, trig_pulse, trig_armed, output_on, resp_valid, err_pulse;
  wire oper_summary, ques_summary, cal_mode, cal_step_pulse, nvm_write;
  wire [15:0] set_volt, set_curr, resp_data, oper_event, oper_enable;
  wire [15:0] ques_event, ques_enable, list_rd_volt, list_rd_curr, list_rd_dwell;
  wire [1:0] cal_step_sel, nvm_parts;
  logic [1:0] last_sel = 2'b00;
  int err_count = 0, comparisons = 0, k;
  int n_trig = 0, n_err = 0, n_resp = 0, n_step = 0, n_nvm = 0;
  int x_trig = 0, x_err = 0, x_resp = 0;
  scp_parser #(.CAL_CODE(24'h0001f4)) DUT (.core_clk, .rst, .rx_data,
    .rx_valid, .get_trig, .fp_cal_active, .meas_volt, .meas_curr, .oper_cond,
    .ques_cond, .list_rd_idx, .trig_pulse, .trig_armed, .set_volt, .set_curr,
    .output_on, .resp_valid, .resp_data, .err_pulse, .oper_event, .oper_enable,
    .ques_event, .ques_enable, .oper_summary, .ques_summary, .cal_mode,
    .cal_step_pulse, .cal_step_sel, .nvm_write, .nvm_parts, .list_count,
    .list_rd_volt, .list_rd_curr, .list_rd_dwell);
  scp_host_model host (.core_clk, .rst, .rx_data, .rx_valid);
  always #10 core_clk = ~core_clk;
  // pulses are counted, so latency slack does not matter
  always @(posedge core_clk) begin
    if (trig_pulse === 1'b1) n_trig++;
    if (err_pulse === 1'b1) n_err++;
    if (resp_valid === 1'b1) n_resp++;
    if (nvm_write === 1'b1) n_nvm++;
    if (cal_step_pulse === 1'b1) begin
      n_step++;
      last_sel = cal_step_sel;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task counts;
    chk(n_trig, x_trig);
    chk(n_err, x_err);
    chk(n_resp, x_resp);
  endtask
  task tx(input string s);
    host.send_msg(s);
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task t_trig;
    tx("TRIG;*TRG");
    get_trig = 1;
    @(posedge core_clk);
    #1 get_trig = 0;
    repeat (3) @(posedge core_clk);
    #1 counts();
    tx("INIT");
    chk(trig_armed, 1);
    tx("TRIG;*trg");
    get_trig = 1;
    @(posedge core_clk);
    #1 get_trig = 0;
    repeat (3) @(posedge core_clk);
    #1 x_trig = 3;
    counts();
    tx("ABOR");
    chk(trig_armed, 0);
    $display("trigger test end");
  endtask
  task t_kw;
    tx("VOLT 5");
    chk(set_volt, 16'h01f4);
    tx("voltage 12.5;CURR 2");
    chk(set_volt, 16'h04e2);
    chk(set_curr, 16'h00c8);
    tx("VOLTA 1");
    x_err++;
    chk(set_volt, 16'h04e2);
    tx("MEAS:VOLT?");
    x_resp++;
    chk(resp_data, 16'h1234);
    tx("meas:curr?;volt?");
    x_resp += 2;
    chk(resp_data, 16'h1234);
    tx(":MEAS:CURR?;:VOLT?");
    x_resp += 2;
    chk(resp_data, 16'h04e2);
    tx("VOLT 3;VO#LT 4;VOLT 9");
    x_err++;
    chk(set_volt, 16'h012c);
    tx("OUTP ON;OUTP?");
    x_resp++;
    chk(output_on, 1);
    chk(resp_data, 16'h0001);
    counts();
    $display("keyword test end");
  endtask
  task t_stat;
    tx("STAT:OPER:ENAB 1");
    oper_cond = 16'hffff;
    ques_cond = 16'h8000;
    repeat (4) @(posedge core_clk);
    #1 chk(oper_event, 16'hffff);
    chk(ques_event, 16'h8000);
    chk(oper_summary, 1);
    chk(oper_enable, 16'h0064);
    tx("STAT:QUES:ENAB 327.69;ENAB?");
    x_resp++;
    chk(resp_data, 16'h8001);
    chk(ques_summary, 1);
    tx("STAT:OPER:EVEN?;:STAT:QUES:COND?");
    x_resp += 2;
    chk(resp_data, 16'h8000);
    chk(oper_event, 16'h0000);
    counts();
    $display("status test end");
  endtask
  task t_list;
    tx("LIST:CLE");
    tx("LIST:VOLT 1;CURR 2;DWEL 0.01");
    chk(list_count, 8'h01);
    chk(list_rd_dwell, 16'h0001);
    chk(list_rd_volt, 16'h0064);
    chk(list_rd_curr, 16'h00c8);
    tx("LIST:DWEL 0;:LIST:DWEL 655.36");
    x_err += 2;
    tx("LIST:DWEL 655.35");
    list_rd_idx = 8'h01;
    repeat (2) @(posedge core_clk);
    #1 chk(list_count, 8'h02);
    chk(list_rd_dwell, 16'hffff);
    for (k = 2; k < 250; k++) host.send_msg("LIST:DWEL 1");
    tx("LIST:DWEL 1");
    x_err++;
    chk(list_count, 8'hfa);
    tx("LIST:DWEL?");
    x_resp++;
    chk(resp_data, 16'h00fa);
    counts();
    $display("list test end");
  endtask
  task t_cal;
    tx("CAL:CODE 4;:CAL:STAT 1");
    fp_cal_active = 1;
    tx("CAL:CODE 5;:CAL:STAT 1");
    x_err += 2;
    chk(cal_mode, 0);
    fp_cal_active = 0;
    tx("CAL:CODE 5;:CAL:STAT 1");
    chk(cal_mode, 1);
    fp_cal_active = 1;
    tx("CAL:VOLT:ZERO");
    fp_cal_active = 0;
    tx("CAL:VOLT:ZERO;:CAL:SAVE");
    x_err += 2;
    chk(n_step, 1);
    chk(n_nvm, 0);
    tx("CAL:VOLT:FULL");
    chk(last_sel, 2'b01);
    tx("CAL:SAVE");
    chk(nvm_parts, 2'b01);
    tx("CAL:CURR:ZERO");
    chk(last_sel, 2'b10);
    tx("CAL:CURR:FULL;:CAL:SAVE");
    chk(last_sel, 2'b11);
    chk(n_nvm, 2);
    tx("CAL:STAT 0");
    chk(cal_mode, 0);
    counts();
    $display("calibration test end");
  endtask
  task end_of_test;
    $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    #1 rst = 0;
    host.gap = 2;
    t_trig();
    t_kw();
    t_stat();
    host.gap = 0;
    t_list();
    t_cal();
    end_of_test();
  end
  // the run needs about 4400 cycles; this is far beyond
  initial begin
    #400000;
    err_count++;
    end_of_test();
  end
endmodule // scp_parser_tb_top
`default_nettype wire
